/* common/slcsp_pkg.sv */
// package: constants and types of the subscriber link codec slave port
package slcsp_pkg;
  // ==========================================
  // link timing
  localparam int CLK_HZ = 20000000;
  localparam int LINK_BIT_RATE = 512000;
  // one link bit in system clock cycles, rounded down
  localparam int LINK_BIT_CYCLES = CLK_HZ / LINK_BIT_RATE;
  localparam logic [3:0] BLOCK_FRAMES = 4'h9;
  // ==========================================
  // frame layout: byte slots 0..7, bits msb first
  localparam logic [2:0] SLOT_VOICE_RX_A = 3'h0;
  localparam logic [2:0] SLOT_VOICE_RX_B = 3'h1;
  localparam logic [2:0] SLOT_FC_RX = 3'h2;
  localparam logic [2:0] SLOT_SIG_RX = 3'h3;
  localparam logic [2:0] SLOT_VOICE_TX_A = 3'h4;
  localparam logic [2:0] SLOT_VOICE_TX_B = 3'h5;
  localparam logic [2:0] SLOT_FC_TX = 3'h6;
  localparam logic [2:0] SLOT_SIG_TX = 3'h7;
  // ==========================================
  // feature control bytes
  localparam int FCB_COUNT = 5;
  localparam logic [2:0] FCB_LAST = 3'h4;
  localparam int FC_F_BIT = 7;
  localparam int FC_WE_BIT = 6;
  localparam int FC_CHSEL_BIT = 0;
  localparam logic [2:0] FCB_IDX_CHSEL = 3'h0;
  localparam logic [2:0] FCB_IDX_ANALOG = 3'h1;
  localparam logic [2:0] FCB_IDX_MODE = 3'h2;
  // analog byte (#2) fields
  localparam int FA_GND_LSB = 0;
  localparam int FA_GAIN6_BIT = 3;
  localparam int FA_TONE_BIT = 4;
  localparam int FA_PDN_BIT = 5;
  // mode byte (#3) fields
  localparam int FM_SECONDARY_INPUT_ENABLE_BIT = 0;
  localparam int FM_RXSCS_BIT = 1;
  localparam int FM_HALF_BIT = 2;
  localparam logic [7:0] FCB_RESET = 8'h00;
  localparam logic [7:0] FCB_ANALOG_RESET = 8'h20;
  // ==========================================
  // wishbone register map (byte addresses)
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_RX_VOICE = 8'h04;
  localparam logic [7:0] ADDR_TX_VOICE = 8'h08;
  localparam logic [7:0] ADDR_TX_SECOND = 8'h0C;
  localparam logic [7:0] ADDR_FCB_BASE = 8'h10;
  localparam logic [7:0] TX_VOICE_RESET = 8'hFF;
  // ==========================================
  // types
  typedef struct packed {
    logic [2:0] balance_ground;
    logic balance_gain_6db;
    logic balance3_or_tone_pin_tone;
    logic tone_inject_enable;
    logic secondary_input_enable;
    logic power_down;
  } slcsp_analog_type;
  typedef struct packed {
    logic configured;
    logic blocked;
    logic selected;
    logic power_down;
    logic strap_b;
  } slcsp_status_type;
  typedef logic [FCB_COUNT-1:0][7:0] slcsp_fcb_type;
endpackage

/* dv/slcsp_link_master.sv */
// link master model: bit clock, direction and datalink for the slave port
`timescale 1ns/1ns
module slcsp_link_master (
  // control and bytes
  input wire logic run_i,
  input wire logic [3:0][7:0] rx_bytes_i,
  // line view
  input wire logic line_i,
  input wire logic oe_i,
  // link outputs
  output logic link_clk_o,
  output logic dir_o,
  output logic dat_o,
  // capture of the transmit half
  output logic [3:0][7:0] tx_bytes_o,
  output logic [3:0] drv_o,
  output int frames_o
);
  logic [3:0][7:0] sh;
  logic [3:0] dv;
  // ==========================================
  // frames, offset from the system clock on purpose
  initial begin
    {link_clk_o, dir_o, dat_o, tx_bytes_o, drv_o, sh, dv} = '0;
    frames_o = 0;
    wait (run_i);
    #13;
    forever begin
      for (int b = 0; b < 64; b++) begin
        // a bit is taken just before the slave moves on
        if (b > 32) sh[(b - 33) / 8] = {sh[(b - 33) / 8][6:0], line_i};
        link_clk_o = 1'b1;
        dir_o = b < 32;
        dat_o = rx_bytes_i[b / 8 % 4][7 - b % 8];
        #200;
        link_clk_o = 1'b0;
        if (b >= 32) dv[(b - 32) / 8] = dv[(b - 32) / 8] | oe_i;
        #200;
      end
      sh[3] = {sh[3][6:0], line_i};
      tx_bytes_o = sh;
      drv_o = dv;
      dv = '0;
      frames_o++;
    end
  end
endmodule

/* dv/slcsp_props.sv */
// checker: bus, reset and link timing properties of the slave port
`timescale 1ns/1ns
module slcsp_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // link and outputs
  input wire logic link_clk_i,
  input wire logic link_direction_frame_i,
  input wire logic line_datalink_o,
  input wire logic line_datalink_oe_o,
  input wire logic slic_select_n_o,
  input wire slcsp_pkg::slcsp_analog_type analog_o,
  input wire logic rx_voice_stb_o
);
  import slcsp_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  // ==========================================
  // bus handshake
  property p_ack_answer; disable iff (rst_i) wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack missing after request");
  property p_ack_pulse; disable iff (rst_i) wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  // ==========================================
  // reset state
  property p_rst_sel; rst_i |=> slic_select_n_o; endproperty
  a_rst_sel: assert property (p_rst_sel) else $error("slic select low in reset");
  property p_rst_quiet; rst_i |=> analog_o.power_down && !line_datalink_oe_o; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("reset state wrong");
  // ==========================================
  // link timing
  property p_oe_rx; disable iff (rst_i) link_direction_frame_i [*5] |-> !line_datalink_oe_o; endproperty
  a_oe_rx: assert property (p_oe_rx) else $error("driver on in receive half");
  // bits move only in the high phase, so the low phase is quiet
  property p_bit_hold;
    disable iff (rst_i)
    line_datalink_oe_o && !link_clk_i && !$past(link_clk_i, 2) && $stable(line_datalink_oe_o)
      |-> $stable(line_datalink_o);
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("data moved in low phase");
  property p_stb_pulse; disable iff (rst_i) rx_voice_stb_o |=> !rx_voice_stb_o [*8]; endproperty
  a_stb_pulse: assert property (p_stb_pulse) else $error("voice strobe repeated");
  property p_stb_rx; disable iff (rst_i) rx_voice_stb_o |-> link_direction_frame_i; endproperty
  a_stb_rx: assert property (p_stb_rx) else $error("voice strobe outside receive half");
endmodule
bind slcsp_top slcsp_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .link_clk_i(link_clk_i), .link_direction_frame_i(link_direction_frame_i),
  .line_datalink_o(line_datalink_o), .line_datalink_oe_o(line_datalink_oe_o),
  .slic_select_n_o(slic_select_n_o), .analog_o(analog_o), .rx_voice_stb_o(rx_voice_stb_o));

/* dv/testbench.sv */
// self-checking bench of the slave port against a link master model
`timescale 1ns/1ns
`define CHK(nm, g, e) begin n_checks++; if ((g) !== (e)) begin errors++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module testbench;
  import slcsp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0, wb_rdat;
  logic wb_ack, link_clk, dir, mdat, dout, oe, slic_n, line, stb;
  logic strap = 1'b0, run = 1'b0, junk = 1'b0, slic_seen = 1'b0;
  logic [7:0] rx_voice;
  slcsp_analog_type analog;
  logic [3:0][7:0] rx = '0, txb;
  logic [3:0] drv;
  int frames, errors = 0, n_checks = 0;
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) junk <= ~junk;
  always @(posedge clk_i) if (!slic_n) slic_seen <= 1'b1;
  // slic select as seen at each link clock fall; the frame's first bit ends up on top
  logic [63:0] scs_pat = '0;
  always @(negedge link_clk) scs_pat <= {scs_pat[62:0], ~slic_n};
  // a released line shows a changing pattern, not the last bit
  assign line = oe ? dout : (dir ? mdat : junk);
  slcsp_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .link_clk_i(link_clk), .link_direction_frame_i(dir), .line_datalink_i(line), .line_datalink_o(dout),
    .line_datalink_oe_o(oe), .channel_strap_i(strap), .slic_select_n_o(slic_n), .analog_o(analog),
    .rx_voice_o(rx_voice), .rx_voice_stb_o(stb));
  slcsp_link_master u_master (.run_i(run), .rx_bytes_i(rx), .line_i(line), .oe_i(oe), .link_clk_o(link_clk),
    .dir_o(dir), .dat_o(mdat), .tx_bytes_o(txb), .drv_o(drv), .frames_o(frames));
  // ==========================================
  // access tasks
  task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic nxt();
    int f;
    f = frames;
    wait (frames != f);
    @(posedge clk_i);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================
  // one run per strap level
  task automatic phase(input logic s);
    logic [31:0] q;
    logic [7:0] fc;
    logic [7:0] an [7];
    logic [7:0] st [7];
    logic [15:0] sp [7];
    an = '{8'h70, 8'h72, 8'h72, 8'h72, 8'h0E, 8'h0C, 8'h0C};
    st = '{8'h8B, 8'h83, {7'h00, s}, {7'h20, s}, 8'h94, 8'h84, {7'h00, ~s}};
    // slic select per frame: receive signalling byte, transmit signalling byte
    sp = '{16'h00FF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, s ? 16'h00F0 : 16'h000F, s ? 16'h00F0 : 16'h000F};
    rst_i <= 1'b1;
    strap <= s;
    rx <= {8'h5A, 7'h20, s, 8'h69, 8'h96};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    run <= 1'b1;
    slic_seen <= 1'b0;
    // the strap reaches status only through its two-flop synchroniser
    repeat (3) @(posedge clk_i);
    xfer(1'b0, ADDR_STATUS, 8'h00, q);
    `CHK("status", q, {27'h0, 4'b0101, s})
    xfer(1'b0, ADDR_TX_VOICE, 8'h00, q);
    `CHK("tx voice reset", q, {24'h0, TX_VOICE_RESET})
    xfer(1'b0, 8'h40, 8'h00, q);
    `CHK("unmapped", q, 32'h0)
    xfer(1'b1, ADDR_TX_VOICE, 8'hA5, q);
    xfer(1'b1, ADDR_TX_SECOND, 8'h3C, q);
    repeat (5) nxt();
    `CHK("blocked", {slic_seen, analog}, 9'h001)
    repeat (6) nxt();
    xfer(1'b0, ADDR_STATUS, 8'h00, q);
    `CHK("status", q, {27'h0, 4'b1011, s})
    `CHK("slic", slic_seen, 1'b1)
    `CHK("rx voice", rx_voice, s ? 8'h69 : 8'h96)
    for (int k = 0; k < 7; k++) begin
      fc = st[k];
      rx[2] <= fc;
      nxt();
      `CHK("analog", analog, an[k])
      `CHK("slots", drv, {1'b0, 1'(k < 6), s, ~s})
      `CHK("slic pattern", scs_pat, {24'h0, sp[k][15:8], 24'h0, sp[k][7:0]})
      `CHK("voice tx", txb[s], an[k][1] ? 8'h3C : 8'hA5)
      if (k < 6) `CHK("feature tx", txb[2], fc)
    end
    xfer(1'b0, ADDR_STATUS, 8'h00, q);
    `CHK("status", q, {27'h0, 4'b1000, s})
    $display("phase strap %0d done", s);
  endtask
  initial begin
    phase(1'b0);
    phase(1'b1);
    close_out();
  end
  initial begin
    #3000000;
    errors++;
    close_out();
  end
endmodule

/* hw/slcsp_fcb_store.sv */
// feature control byte storage
`timescale 1ns/1ns
module slcsp_fcb_store (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // write port
  input wire logic wr_i,
  input wire logic [2:0] wr_idx_i,
  input wire logic [7:0] wr_data_i,
  // contents
  output slcsp_pkg::slcsp_fcb_type fcb_o
);
  import slcsp_pkg::*;
  genvar g;
  generate
    for (g = 0; g < FCB_COUNT; g++) begin : g_byte
      localparam logic [7:0] RST_VAL = (g == 1) ? FCB_ANALOG_RESET : FCB_RESET;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          fcb_o[g] <= RST_VAL;
        end else if (wr_i && wr_idx_i == 3'(g)) begin
          fcb_o[g] <= wr_data_i;
        end
      end
    end
  endgenerate
endmodule

/* hw/slcsp_sync.sv */
// two-stage synchronisers with edge detection for link pins
`timescale 1ns/1ns
module slcsp_sync #(
  parameter int W = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // raw pins and synchronised view
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  // edges stay masked until the history flop holds a real sample, so a pin
  // that is already high when reset ends is not taken for a fresh edge
  logic [2:0] live_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      live_reg <= 3'h0;
    end else begin
      live_reg <= {live_reg[1:0], 1'b1};
    end
  end

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      logic last_reg;
      // only sync_reg looks at meta_reg
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
          last_reg <= 1'b0;
        end else begin
          meta_reg <= pin_i[g];
          sync_reg <= meta_reg;
          last_reg <= sync_reg;
        end
      end
      assign level_o[g] = sync_reg;
      assign rise_o[g] = sync_reg & ~last_reg & live_reg[2];
      assign fall_o[g] = ~sync_reg & last_reg & live_reg[2];
    end
  endgenerate
endmodule

/* hw/slcsp_top.sv */
// subscriber link codec slave port: link timing, voice, feature control, slic select
//
// Function
// RQ1 - direction high receives, low enables driver
// RQ2 - 512 kbps bits shifted by link clock
// RQ3 - touch line only in own channel fields
// RQ4 - strap low channel A, high B
// RQ5 - channel A: rx byte 1, tx byte 5
// RQ6 - channel B: rx byte 2, tx byte 6
// RQ7 - feature bytes exchanged only once selected
// RQ8 - select when byte1 lsb equals strap
// RQ9 - stay selected until new framing byte
// RQ10 - header 00 returns select bit byte 7
// RQ11 - high impedance in eighth byte
// RQ12 - ignore signalling data, pulse slic select
// RQ13 - slic select low grants signalling processing
// RQ14 - secondary enable picks secondary sample
// RQ15 - received voice byte made parallel
// RQ16 - feature bits choose balance3 or tone
// RQ17 - any combination of three grounding switches; code holds the third off while the shared pin is in tone mode
// RQ18 - balance path gain 0 or 6 dB
// RQ19 - tone added only when programmed
// RQ20 - framing derived from direction rising edge
// RQ21 - bytes shifted msb first
// RQ22 - framing bit starts/advances, write on complement
// RQ23 - block nine frames, power down, select high
// RQ24 - sample on clock fall, drive on rise
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
module slcsp_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // link pins
  input wire logic link_clk_i,
  input wire logic link_direction_frame_i,
  input wire logic line_datalink_i,
  output logic line_datalink_o,
  output logic line_datalink_oe_o,
  input wire logic channel_strap_i,
  output logic slic_select_n_o,
  // analog control and voice path
  output slcsp_pkg::slcsp_analog_type analog_o,
  output logic [7:0] rx_voice_o,
  output logic rx_voice_stb_o
);
  import slcsp_pkg::*;

  // ==========================================
  // pin synchronisation
  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  logic lclk_rise;
  logic lclk_fall;
  logic dir_lvl;
  logic dir_rise;
  logic din;
  logic [1:0] strap_sync;

  slcsp_sync #(.W(3)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({line_datalink_i, link_direction_frame_i, link_clk_i}),
    .level_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  assign lclk_rise = pin_rise[0];
  assign lclk_fall = pin_fall[0];
  assign dir_lvl = pin_lvl[1];
  assign dir_rise = pin_rise[1];
  assign din = pin_lvl[2];

  // strap is a slow pin but still crosses into this domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_sync <= 2'h0;
    end else begin
      strap_sync <= {strap_sync[0], channel_strap_i};
    end
  end

  logic strap_b;
  assign strap_b = strap_sync[1]; // see RQ4

  // ==========================================
  // frame bit counter
  logic [5:0] bit_cnt_reg;
  logic [2:0] slot;
  logic [2:0] bit_in_byte;
  logic last_bit;

  assign slot = bit_cnt_reg[5:3];
  assign bit_in_byte = bit_cnt_reg[2:0];
  assign last_bit = (bit_in_byte == 3'h7);

  // the counter advances after each sampling edge, so between a fall and
  // the next rise it already names the bit that is about to be driven
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_cnt_reg <= 6'h00;
    end else if (dir_rise) begin
      bit_cnt_reg <= 6'h00; // see RQ20
    end else if (lclk_fall) begin
      bit_cnt_reg <= bit_cnt_reg + 6'h01; // see RQ2
    end
  end

  // ==========================================
  // power-up blocking of feature control
  logic [3:0] frame_cnt_reg;
  logic blocked;

  assign blocked = (frame_cnt_reg != BLOCK_FRAMES);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_cnt_reg <= 4'h0;
    end else if (dir_rise && blocked) begin
      frame_cnt_reg <= frame_cnt_reg + 4'h1; // see RQ23
    end
  end

  // ==========================================
  // receive shifter
  logic [7:0] rx_shift_reg;
  logic [7:0] rx_byte;
  logic rx_sample;
  logic rx_done;

  assign rx_sample = lclk_fall & dir_lvl & ~bit_cnt_reg[5]; // see RQ1 see RQ24
  assign rx_byte = {rx_shift_reg[6:0], din}; // see RQ21
  assign rx_done = rx_sample & last_bit;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_shift_reg <= 8'h00;
    end else if (rx_sample) begin
      rx_shift_reg <= rx_byte;
    end
  end

  // voice byte handed over in parallel form
  logic [2:0] rx_voice_slot;
  logic [2:0] tx_voice_slot;

  assign rx_voice_slot = strap_b ? SLOT_VOICE_RX_B : SLOT_VOICE_RX_A; // see RQ5 see RQ6
  assign tx_voice_slot = strap_b ? SLOT_VOICE_TX_B : SLOT_VOICE_TX_A; // see RQ5 see RQ6

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_voice_o <= 8'h00;
      rx_voice_stb_o <= 1'b0;
    end else begin
      rx_voice_stb_o <= rx_done && slot == rx_voice_slot;
      if (rx_done && slot == rx_voice_slot) begin
        rx_voice_o <= rx_byte; // see RQ15
      end
    end
  end

  // ==========================================
  // feature control receive
  logic selected_reg;
  logic configured_reg;
  logic status_req_reg;
  logic chsel_bit_reg;
  logic [2:0] fc_idx_reg;
  logic fc_take;
  logic fc_f;
  logic fc_we_ok;
  logic fc_match;
  logic fc_wr;
  logic [2:0] fc_wr_idx;
  slcsp_fcb_type fcb;

  assign fc_take = rx_done && slot == SLOT_FC_RX && !blocked; // see RQ23
  assign fc_f = rx_byte[FC_F_BIT];
  assign fc_we_ok = rx_byte[FC_WE_BIT] ^ rx_byte[FC_F_BIT]; // see RQ22
  assign fc_match = (rx_byte[FC_CHSEL_BIT] == strap_b); // see RQ8
  assign fc_wr_idx = fc_f ? fc_idx_reg + 3'h1 : FCB_IDX_CHSEL;
  // a write lands only in a device selected by this or an earlier framing byte
  assign fc_wr = fc_take && fc_we_ok && (fc_f ? selected_reg && fc_idx_reg != FCB_LAST : fc_match); // see RQ7

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      selected_reg <= 1'b0;
      fc_idx_reg <= 3'h0;
      chsel_bit_reg <= 1'b0;
    end else if (fc_take) begin
      if (!fc_f) begin
        selected_reg <= fc_match; // see RQ9
        fc_idx_reg <= FCB_IDX_CHSEL; // see RQ22
        chsel_bit_reg <= rx_byte[FC_CHSEL_BIT];
      end else if (fc_idx_reg != FCB_LAST) begin
        fc_idx_reg <= fc_idx_reg + 3'h1; // see RQ22
      end
    end
  end

  // status answer only in the frame that asked for it
  always_ff @(posedge clk_i) begin
    if (rst_i || dir_rise) begin
      status_req_reg <= 1'b0;
    end else if (fc_take) begin
      status_req_reg <= (rx_byte[FC_F_BIT:FC_WE_BIT] == 2'b00); // see RQ10
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      configured_reg <= 1'b0;
    end else if (fc_wr && fc_wr_idx == FCB_IDX_CHSEL) begin
      configured_reg <= 1'b1; // see RQ23
    end
  end

  slcsp_fcb_store u_fcb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(fc_wr),
    .wr_idx_i(fc_wr_idx),
    .wr_data_i(rx_byte),
    .fcb_o(fcb)
  );

  // ==========================================
  // analog control decode
  logic tone_mode;
  logic [2:0] gnd_raw;
  assign tone_mode = fcb[FCB_IDX_ANALOG][FA_TONE_BIT];
  assign gnd_raw = fcb[FCB_IDX_ANALOG][FA_GND_LSB +: 3];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_o <= '0;
      analog_o.power_down <= 1'b1;
    end else begin
      // third switch only exists while the shared pin is a balance input
      analog_o.balance_ground <= {gnd_raw[2] & ~tone_mode, gnd_raw[1:0]}; // see RQ17 see RQ16
      analog_o.balance_gain_6db <= fcb[FCB_IDX_ANALOG][FA_GAIN6_BIT]; // see RQ18
      analog_o.balance3_or_tone_pin_tone <= tone_mode; // see RQ16
      analog_o.tone_inject_enable <= tone_mode; // see RQ19
      analog_o.secondary_input_enable <= fcb[FCB_IDX_MODE][FM_SECONDARY_INPUT_ENABLE_BIT]; // see RQ14
      analog_o.power_down <= fcb[FCB_IDX_ANALOG][FA_PDN_BIT]; // see RQ23
    end
  end

  // ==========================================
  // transmit path
  logic [7:0] tx_voice_reg;
  logic [7:0] tx_second_reg;
  logic [7:0] tx_fc_byte;
  logic [7:0] tx_byte;
  logic drive_slot;
  logic line_oe_reg;

  assign tx_fc_byte = status_req_reg ? {7'h00, chsel_bit_reg} : fcb[fc_idx_reg]; // see RQ10

  always_comb begin
    tx_byte = 8'h00;
    drive_slot = 1'b0;
    if (slot == tx_voice_slot) begin
      // switches immediately: the next voice byte already uses the new source
      tx_byte = fcb[FCB_IDX_MODE][FM_SECONDARY_INPUT_ENABLE_BIT] ? tx_second_reg : tx_voice_reg; // see RQ14
      drive_slot = 1'b1; // see RQ3
    end else if (slot == SLOT_FC_TX) begin
      tx_byte = tx_fc_byte;
      drive_slot = selected_reg & ~blocked; // see RQ7
    end
    // signalling slot and other channel fall through undriven
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || dir_rise) begin
      line_datalink_o <= 1'b0;
      line_oe_reg <= 1'b0;
    end else if (lclk_rise && bit_cnt_reg[5]) begin
      line_datalink_o <= tx_byte[3'h7 - bit_in_byte]; // see RQ21 see RQ24
      line_oe_reg <= drive_slot && slot != SLOT_SIG_TX; // see RQ11
    end
  end

  assign line_datalink_oe_o = line_oe_reg & ~dir_lvl; // see RQ1

  // ==========================================
  // slic select
  logic scs_rx;
  logic scs_tx;
  logic half_mode;
  assign half_mode = fcb[FCB_IDX_MODE][FM_HALF_BIT];
  assign scs_rx = dir_lvl && slot == SLOT_SIG_RX && selected_reg && fcb[FCB_IDX_MODE][FM_RXSCS_BIT];
  // half mode lets both channels' slics share the one transmit slot
  assign scs_tx = !dir_lvl && slot == SLOT_SIG_TX &&
                  (half_mode ? (bit_in_byte[2] ^ strap_b) : selected_reg);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slic_select_n_o <= 1'b1;
    end else begin
      slic_select_n_o <= ~(configured_reg && (scs_rx || scs_tx)); // see RQ12 see RQ13 see RQ23
    end
  end

  // ==========================================
  // wishbone slave
  logic wb_req;
  logic [7:0] fcb_off;
  slcsp_status_type status;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign fcb_off = wb_adr_i - ADDR_FCB_BASE;
  assign status = '{configured: configured_reg, blocked: blocked, selected: selected_reg,
                    power_down: analog_o.power_down, strap_b: strap_b};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_voice_reg <= TX_VOICE_RESET;
      tx_second_reg <= TX_VOICE_RESET;
    end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == ADDR_TX_VOICE) begin
        tx_voice_reg <= wb_dat_i[7:0];
      end
      if (wb_adr_i == ADDR_TX_SECOND) begin
        tx_second_reg <= wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_req) begin
      wb_dat_o <= 32'h00000000;
      if (wb_adr_i == ADDR_STATUS) begin
        wb_dat_o <= {27'h0000000, status};
      end else if (wb_adr_i == ADDR_RX_VOICE) begin
        wb_dat_o <= {24'h000000, rx_voice_o};
      end else if (wb_adr_i == ADDR_TX_VOICE) begin
        wb_dat_o <= {24'h000000, tx_voice_reg};
      end else if (wb_adr_i == ADDR_TX_SECOND) begin
        wb_dat_o <= {24'h000000, tx_second_reg};
      end else if (wb_adr_i[1:0] == 2'h0 && wb_adr_i >= ADDR_FCB_BASE && fcb_off[7:2] < 6'(FCB_COUNT)) begin
        wb_dat_o <= {24'h000000, fcb[fcb_off[4:2]]};
      end
    end
  end
endmodule
